// ### design/ssc_status_ctrl.sv
/*
 * Status and control generator between an 8-bit processor and the system bus.
 * Latches write data, derives status lines, makes the cycle-start pulse and
 * the read and write strobes, and floats each group under its disable line.
 * Assumes processor strobes and bus disable lines are asynchronous to i_clk
 * and the board's tristate pads resolve the _oe outputs.
 */
// Behaviour
// - Data-out latch follows phase2 high, holds after
// - Data-out disable low floats data drivers
// - Status disable low floats status group
// - sM1 high during opcode fetch
// - sOUT high on write with I/O
// - sINP read and I/O, latched in sync
// - sMEMR read and memory, latched in sync
// - sWO low unless read or interrupt ack, latched in sync
// - sINTA high on I/O with opcode fetch
// - Control group floats while control disable low
// - sHLTA follows halt ack, never floats
// - Sync triggers on I/O or non-refresh memory
// - Sync stays high 5 cycles, about 250 ns
// - Stable-status strobe never driven
// - Sixteen-bit transfer request never driven
// - pDBIN high on read or interrupt ack
// - pWR follows write strobe slightly delayed
`timescale 1ns/100ps
module ssc_status_ctrl
	import ssc_pkg::*;
(
	input wire logic i_clk, // 20 MHz system clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_system_clock_phase2, // Bus phase-2 clock level
	input wire logic [SSC_DATA_W-1:0] i_cpu_data, // Processor data bus
	input wire logic i_cpu_opcode_fetch_n, // Opcode fetch, active low
	input wire logic i_cpu_io_request_n, // I/O request, active low
	input wire logic i_cpu_mem_request_n, // Memory request, active low
	input wire logic i_cpu_refresh_n, // Refresh cycle, active low
	input wire logic i_cpu_halt_ack_n, // Halt acknowledge, active low
	input wire logic i_cpu_rd_n, // Processor read, active low
	input wire logic i_cpu_wr_n, // Processor write, active low
	input wire logic i_data_out_dis_n, // Data-out disable line
	input wire logic i_status_dis_n, // Status disable line
	input wire logic i_ctrl_dis_n, // Control disable line
	output logic [SSC_DATA_W-1:0] o_data_out, // Latched bus data
	output logic o_data_out_oe, // Data-out drive enable
	output logic o_s_m1, // Opcode fetch status
	output logic o_s_out, // I/O output status
	output logic o_s_inp, // I/O input status
	output logic o_s_memr, // Memory read status
	output logic o_s_write_out_n, // Write-follows status, active low
	output logic o_status_oe, // Status group drive enable
	output logic o_s_intr_ack_cycle, // Interrupt acknowledge status
	output logic o_p_sync, // Bus cycle start pulse
	output logic o_p_dbin, // Read strobe
	output logic o_p_wr_n, // Write strobe, active low
	output logic o_ctrl_oe, // Control group drive enable
	output logic o_s_cpu_halt_ack_n, // Halt acknowledge status
	output logic o_p_stval_n_oe, // Stable-status strobe enable
	output logic o_s_xtrq_n_oe // Sixteen-bit request enable
);

	localparam int unsigned NSYNC = 13;

	// Two-stage synchronisers for every asynchronous input
	logic [NSYNC-1:0] meta_q, meta_d;
	logic [NSYNC-1:0] sync_q, sync_d;
	logic [SSC_DATA_W-1:0] data_meta_q, data_meta_d, data_sync_q, data_sync_d;

	always_comb
	begin
		meta_d = {i_system_clock_phase2, i_cpu_opcode_fetch_n, i_cpu_io_request_n,
			i_cpu_mem_request_n, i_cpu_refresh_n, i_cpu_halt_ack_n, i_cpu_rd_n,
			i_cpu_wr_n, i_data_out_dis_n, i_status_dis_n, i_ctrl_dis_n, 1'b0, 1'b0};
		sync_d = meta_q;
		data_meta_d = i_cpu_data;
		data_sync_d = data_meta_q;
	end

	// Reset values are the idle (deasserted) levels of each line except phase2, which resets high
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			meta_q <= 13'h1FFC;
			sync_q <= 13'h1FFC;
			data_meta_q <= 8'h00;
			data_sync_q <= 8'h00;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			data_meta_q <= data_meta_d;
			data_sync_q <= data_sync_d;
		end
	end

	// Synchronised levels, named by use
	logic phase2, fetch_n, ioreq_n, memreq_n, refresh_n, halt_n, rd_n, wr_n;
	logic dodis_n, stdis_n, ccdis_n;
	assign {phase2, fetch_n, ioreq_n, memreq_n, refresh_n, halt_n, rd_n, wr_n,
		dodis_n, stdis_n, ccdis_n} = sync_q[NSYNC-1:2];

	// Combinational status terms
	logic intr_ack_cycle, inp_raw, memr_raw, write_out_raw_n, sync_trig_lvl;
	always_comb
	begin
		intr_ack_cycle = !ioreq_n && !fetch_n;
		inp_raw = !rd_n && !ioreq_n;
		memr_raw = !rd_n && !memreq_n;
		write_out_raw_n = !(rd_n && !intr_ack_cycle);
		// Trigger on I/O or non-refresh memory
		sync_trig_lvl = !ioreq_n || (!memreq_n && refresh_n);
	end

	// Registered state and outputs
	logic [SSC_SYNC_CNT_W-1:0] sync_cnt_q, sync_cnt_d;
	logic trig_prev_q, trig_prev_d;
	logic [SSC_DATA_W-1:0] data_out_q, data_out_d;
	logic data_oe_q, data_oe_d;
	logic m1_q, m1_d, out_q, out_d, inp_q, inp_d, memr_q, memr_d;
	logic wo_n_q, wo_n_d, status_oe_q, status_oe_d;
	logic intr_ack_cycle_q, intr_ack_cycle_d, psync_q, psync_d, dbin_q, dbin_d, pwr_n_q, pwr_n_d;
	logic ctrl_oe_q, ctrl_oe_d, cpu_halt_ack_n_q, cpu_halt_ack_n_d;

	// Next-state logic for all outputs except the two unused enables
	always_comb
	begin
		trig_prev_d = sync_trig_lvl;
		sync_cnt_d = sync_cnt_q;
		if (sync_trig_lvl && !trig_prev_q)
			sync_cnt_d = SSC_SYNC_CYCLES;
		else if (sync_cnt_q != SSC_CNT_ZERO)
			sync_cnt_d = sync_cnt_q - SSC_CNT_ONE;
		// High for the loaded cycle count
		psync_d = (sync_cnt_d != SSC_CNT_ZERO);
		// Transparent in phase2 high, holds otherwise
		data_out_d = phase2 ? data_sync_q : data_out_q;
		data_oe_d = dodis_n;
		m1_d = !fetch_n;
		out_d = !wr_n && !ioreq_n;
		// Input status latched while sync high
		inp_d = psync_q ? inp_raw : inp_q;
		// Memory read latched while sync high
		memr_d = psync_q ? memr_raw : memr_q;
		wo_n_d = psync_q ? write_out_raw_n : wo_n_q;
		status_oe_d = stdis_n;
		intr_ack_cycle_d = intr_ack_cycle;
		// Read strobe from read or ack
		dbin_d = !rd_n || intr_ack_cycle;
		// Registered copy gives the small delay
		pwr_n_d = wr_n;
		ctrl_oe_d = ccdis_n;
		cpu_halt_ack_n_d = !halt_n;
	end

	// Output registers; idle levels under reset
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			sync_cnt_q <= SSC_CNT_ZERO;
			trig_prev_q <= 1'b0;
			data_out_q <= 8'h00;
			data_oe_q <= 1'b0;
			m1_q <= SSC_RST_STATUS;
			out_q <= SSC_RST_STATUS;
			inp_q <= SSC_RST_STATUS;
			memr_q <= SSC_RST_STATUS;
			wo_n_q <= SSC_RST_WRITE_OUT_N;
			status_oe_q <= 1'b0;
			intr_ack_cycle_q <= SSC_RST_STATUS;
			psync_q <= 1'b0;
			dbin_q <= 1'b0;
			pwr_n_q <= SSC_RST_WR_N;
			ctrl_oe_q <= 1'b0;
			cpu_halt_ack_n_q <= SSC_RST_STATUS;
		end
		else
		begin
			sync_cnt_q <= sync_cnt_d;
			trig_prev_q <= trig_prev_d;
			data_out_q <= data_out_d;
			data_oe_q <= data_oe_d;
			m1_q <= m1_d;
			out_q <= out_d;
			inp_q <= inp_d;
			memr_q <= memr_d;
			wo_n_q <= wo_n_d;
			status_oe_q <= status_oe_d;
			intr_ack_cycle_q <= intr_ack_cycle_d;
			psync_q <= psync_d;
			dbin_q <= dbin_d;
			pwr_n_q <= pwr_n_d;
			ctrl_oe_q <= ctrl_oe_d;
			cpu_halt_ack_n_q <= cpu_halt_ack_n_d;
		end
	end

	// Port assignments straight from flip-flops
	assign o_data_out = data_out_q;
	assign o_data_out_oe = data_oe_q;
	assign o_s_m1 = m1_q;
	assign o_s_out = out_q;
	assign o_s_inp = inp_q;
	assign o_s_memr = memr_q;
	assign o_s_write_out_n = wo_n_q;
	assign o_status_oe = status_oe_q;
	assign o_s_intr_ack_cycle = intr_ack_cycle_q;
	assign o_p_sync = psync_q;
	assign o_p_dbin = dbin_q;
	assign o_p_wr_n = pwr_n_q;
	assign o_ctrl_oe = ctrl_oe_q;
	assign o_s_cpu_halt_ack_n = cpu_halt_ack_n_q;
	// Unused lines never enabled; tied zero bits of the sync chain
	assign o_p_stval_n_oe = sync_q[1];
	assign o_s_xtrq_n_oe = sync_q[0];

endmodule : ssc_status_ctrl

// ### design/ssc_pkg.sv
/*
 * Package for the processor-to-system-bus status and control generator.
 * Holds timing constants for the cycle-start pulse; assumes a 20 MHz i_clk.
 */
package ssc_pkg;
	// System clock period in ns
	localparam int unsigned SSC_CLK_PERIOD_NS = 50;
	// Cycle-start pulse width as specified, in ns
	localparam int unsigned SSC_SYNC_WIDTH_NS = 270;
	// Longest width rounds down: 270/50 -> 5 cycles
	localparam int unsigned SSC_SYNC_CYCLES_I = (SSC_SYNC_WIDTH_NS / SSC_CLK_PERIOD_NS) < 1 ? 1
		: (SSC_SYNC_WIDTH_NS / SSC_CLK_PERIOD_NS);
	// Counter width for the pulse down-counter
	localparam int unsigned SSC_SYNC_CNT_W = 4;
	localparam logic [SSC_SYNC_CNT_W-1:0] SSC_SYNC_CYCLES = SSC_SYNC_CYCLES_I[SSC_SYNC_CNT_W-1:0];
	localparam logic [SSC_SYNC_CNT_W-1:0] SSC_CNT_ZERO = 4'h0;
	localparam logic [SSC_SYNC_CNT_W-1:0] SSC_CNT_ONE = 4'h1;
	// Data-out bus width
	localparam int unsigned SSC_DATA_W = 8;
	// Reset values of the status and strobe outputs
	localparam logic SSC_RST_STATUS = 1'b0;
	localparam logic SSC_RST_WRITE_OUT_N = 1'b1;
	localparam logic SSC_RST_WR_N = 1'b1;
endpackage : ssc_pkg

// ### sim/ssc_chk.sv
/* Port checker for the status and control generator.
 * Assumes strobes held idle during reset and three-edge latency. */
`timescale 1ns/100ps
module ssc_chk
	import ssc_pkg::*;
(
	input wire logic i_clk, i_rst_n, i_system_clock_phase2, i_cpu_opcode_fetch_n,
	input wire logic i_cpu_io_request_n, i_cpu_mem_request_n, i_cpu_rd_n, i_cpu_wr_n,
	input wire logic i_cpu_halt_ack_n,
	input wire logic i_data_out_dis_n, i_status_dis_n, i_ctrl_dis_n,
	input wire logic [SSC_DATA_W-1:0] i_cpu_data, o_data_out,
	input wire logic o_data_out_oe, o_s_m1, o_s_out, o_s_inp, o_s_memr, o_s_write_out_n,
	input wire logic o_status_oe, o_s_intr_ack_cycle, o_p_sync, o_p_dbin, o_p_wr_n,
	input wire logic o_ctrl_oe, o_s_cpu_halt_ack_n, o_p_stval_n_oe, o_s_xtrq_n_oe
);
	logic [1:0] up_q;
	logic [1:0] up_d;
	logic ok;
	// Edges since release; $past is trusted only once synchronisers refill
	always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
	always_ff @(posedge i_clk) up_q <= i_rst_n ? up_d : 2'h0;
	assign ok = (up_q == 2'h3);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_dout; ok && $past(i_system_clock_phase2, 3) |-> o_data_out == $past(i_cpu_data, 3); endproperty
	a_dout: assert property (p_dout) else $error("data out not following");
	property p_oe; ok |-> {o_data_out_oe, o_status_oe, o_ctrl_oe} == $past({i_data_out_dis_n, i_status_dis_n, i_ctrl_dis_n}, 3); endproperty
	a_oe: assert property (p_oe) else $error("drive enable wrong");
	property p_m1; ok |-> o_s_m1 == !$past(i_cpu_opcode_fetch_n, 3); endproperty
	a_m1: assert property (p_m1) else $error("fetch status wrong");
	property p_out; ok |-> o_s_out == $past(!i_cpu_wr_n && !i_cpu_io_request_n, 3); endproperty
	a_out: assert property (p_out) else $error("output status wrong");
	property p_hold; ok && !$past(o_p_sync) |-> $stable({o_s_inp, o_s_memr, o_s_write_out_n}); endproperty
	a_hold: assert property (p_hold) else $error("latched status moved");
	// Latches must take the decoded cycle type while sync is high
	property p_latch; ok && $past(o_p_sync) |-> {o_s_inp, o_s_memr, o_s_write_out_n} ==
		$past({!i_cpu_rd_n && !i_cpu_io_request_n, !i_cpu_rd_n && !i_cpu_mem_request_n,
		!i_cpu_rd_n || (!i_cpu_io_request_n && !i_cpu_opcode_fetch_n)}, 3); endproperty
	a_latch: assert property (p_latch) else $error("latched status not loaded");
	property p_intr_ack_cycle; ok |-> o_s_intr_ack_cycle == $past(!i_cpu_io_request_n && !i_cpu_opcode_fetch_n, 3); endproperty
	a_intr_ack_cycle: assert property (p_intr_ack_cycle) else $error("ack status wrong");
	property p_cpu_halt_ack_n; ok |-> o_s_cpu_halt_ack_n == !$past(i_cpu_halt_ack_n, 3); endproperty
	a_cpu_halt_ack_n: assert property (p_cpu_halt_ack_n) else $error("halt status wrong");
	property p_sync; $rose(o_p_sync) |-> o_p_sync [*5]; endproperty
	a_sync: assert property (p_sync) else $error("sync pulse short");
	property p_nodrv; !o_p_stval_n_oe && !o_s_xtrq_n_oe; endproperty
	a_nodrv: assert property (p_nodrv) else $error("unused line driven");
	property p_dbin; ok |-> o_p_dbin == $past(!i_cpu_rd_n || (!i_cpu_io_request_n && !i_cpu_opcode_fetch_n), 3); endproperty
	a_dbin: assert property (p_dbin) else $error("read strobe wrong");
	property p_wr; ok |-> o_p_wr_n == $past(i_cpu_wr_n, 3); endproperty
	a_wr: assert property (p_wr) else $error("write strobe wrong");
endmodule : ssc_chk
bind ssc_status_ctrl ssc_chk u_chk (.*);

// ### sim/ssc_bus_card.sv
/* Bus card model: a temporary master that takes the bus by pulling the
 * disable lines low, and counts driven cycle-start pulses. */
`timescale 1ns/100ps
module ssc_bus_card (
	input wire logic i_clk, // System clock
	input wire logic i_take, // Hold the bus
	input wire logic i_p_sync, // Cycle start seen
	input wire logic i_ctrl_oe, // Sync driven
	output logic o_data_out_dis_n, o_status_dis_n, o_ctrl_dis_n, // Disable lines
	output int o_syncs // Pulses counted
);
	logic seen_q = 1'b0;
	int n = 0;
	// disables pulled low while holding the bus
	assign {o_data_out_dis_n, o_status_dis_n, o_ctrl_dis_n} = {3{!i_take}};
	assign o_syncs = n;
	// Floated sync is ignored, as a real card would not see it
	always @(posedge i_clk)
	begin
		seen_q <= i_p_sync && i_ctrl_oe;
		if (i_p_sync && i_ctrl_oe && !seen_q)
			n <= n + 1;
	end
endmodule : ssc_bus_card

// ### sim/tb_top.sv
/* Self-checking bench for the status and control generator.
 * Assumes a 20 MHz clock and three-edge input latency. */
`timescale 1ns/100ps
module tb_top;
	import ssc_pkg::*;
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_system_clock_phase2 = 1'b0, take = 1'b0;
	logic i_cpu_opcode_fetch_n = 1'b1, i_cpu_io_request_n = 1'b1, i_cpu_mem_request_n = 1'b1;
	logic i_cpu_refresh_n = 1'b1, i_cpu_halt_ack_n = 1'b1, i_cpu_rd_n = 1'b1, i_cpu_wr_n = 1'b1;
	logic [SSC_DATA_W-1:0] i_cpu_data = 8'h00, o_data_out;
	logic i_data_out_dis_n, i_status_dis_n, i_ctrl_dis_n, o_data_out_oe, o_s_m1, o_s_out;
	logic o_s_inp, o_s_memr, o_s_write_out_n, o_status_oe, o_s_intr_ack_cycle, o_p_sync;
	logic o_p_dbin, o_p_wr_n, o_ctrl_oe, o_s_cpu_halt_ack_n, o_p_stval_n_oe, o_s_xtrq_n_oe;
	int n_mismatch = 0, cmp_count = 0, syncs, s0;
	always #25 i_clk = !i_clk;
	ssc_status_ctrl u_dut (.*);
	ssc_bus_card u_card (.i_clk(i_clk), .i_take(take), .i_p_sync(o_p_sync),
		.i_ctrl_oe(o_ctrl_oe), .o_data_out_dis_n(i_data_out_dis_n),
		.o_status_dis_n(i_status_dis_n), .o_ctrl_dis_n(i_ctrl_dis_n), .o_syncs(syncs));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Inputs move on falling edges only
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc
	// I/O read then memory read, each must start one cycle
	task automatic t_io_read();
		for (int i = 0; i < 2; i++)
		begin
			s0 = syncs;
			{i_cpu_io_request_n, i_cpu_mem_request_n, i_cpu_rd_n} = {i == 1, i == 0, 1'b0};
			cyc(4);
			chk("sync", o_p_sync, 8'h01);
			chk("dbin", o_p_dbin, 8'h01);
			cyc(6);
			chk("sync end", o_p_sync, 8'h00);
			chk("status", {o_s_inp, o_s_memr, o_s_write_out_n}, (i == 0) ? 8'h05 : 8'h03);
			chk("pulses", 8'(syncs - s0), 8'h01);
			{i_cpu_io_request_n, i_cpu_mem_request_n, i_cpu_rd_n} = 3'b111;
			cyc(4);
		end
	endtask : t_io_read
	// Memory write then I/O write, each must start one cycle
	task automatic t_write();
		for (int i = 0; i < 2; i++)
		begin
			s0 = syncs;
			{i_cpu_io_request_n, i_cpu_mem_request_n, i_cpu_wr_n} = {i == 0, i == 1, 1'b0};
			cyc(10);
			chk("out", o_s_out, 8'(i));
			chk("wr", o_p_wr_n, 8'h00);
			chk("status", {o_s_inp, o_s_memr, o_s_write_out_n}, 8'h00);
			chk("pulses", 8'(syncs - s0), 8'h01);
			{i_cpu_io_request_n, i_cpu_mem_request_n, i_cpu_wr_n} = 3'b111;
			cyc(4);
		end
		// A refresh cycle must not start a bus cycle
		s0 = syncs;
		{i_cpu_mem_request_n, i_cpu_refresh_n} = 2'b00;
		cyc(10);
		chk("refresh", 8'(syncs - s0), 8'h00);
		{i_cpu_mem_request_n, i_cpu_refresh_n} = 2'b11;
		cyc(4);
	endtask : t_write
	task automatic t_intr_ack_cycle();
		{i_cpu_io_request_n, i_cpu_opcode_fetch_n} = 2'b00;
		cyc(10);
		chk("ack", {o_s_intr_ack_cycle, o_s_m1, o_p_dbin, o_s_write_out_n}, 8'h0F);
		{i_cpu_io_request_n, i_cpu_opcode_fetch_n} = 2'b11;
		cyc(4);
	endtask : t_intr_ack_cycle
	task automatic t_float();
		take = 1'b1;
		i_cpu_halt_ack_n = 1'b0;
		cyc(4);
		chk("oe", {o_data_out_oe, o_status_oe, o_ctrl_oe, o_s_cpu_halt_ack_n}, 8'h01);
		take = 1'b0;
		i_cpu_halt_ack_n = 1'b1;
		cyc(4);
		chk("oe", {o_data_out_oe, o_status_oe, o_ctrl_oe, o_s_cpu_halt_ack_n}, 8'h0E);
	endtask : t_float
	task automatic t_data();
		{i_system_clock_phase2, i_cpu_data} = {1'b1, 8'hA5};
		cyc(4);
		chk("data", o_data_out, 8'hA5);
		{i_system_clock_phase2, i_cpu_data} = {1'b0, 8'h3C};
		cyc(4);
		chk("data", o_data_out, 8'hA5);
	endtask : t_data
	task automatic results();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// Watchdog well past the 107 or so cycles the tests need
	initial
	begin
		#100000;
		n_mismatch++;
		results();
	end
	initial
	begin
		cyc(5);
		i_rst_n = 1'b1;
		cyc(2);
		t_io_read();
		t_write();
		t_intr_ack_cycle();
		t_float();
		t_data();
		results();
	end
endmodule : tb_top
